// ==== include/upc_pkg.sv ====
// shared constants, types and state layout of the serial player command block
package upc_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int BAUD = 115200;
	localparam int BAUD_DIV_I = (CLK_HZ + BAUD / 2) / BAUD;
	localparam logic [8:0] BAUD_DIV = 9'(BAUD_DIV_I);
	localparam logic [8:0] BAUD_HALF = 9'(BAUD_DIV_I / 2);
	localparam int MSG_BYTES = 20;
	localparam int LINE_BYTES = 13;
	localparam int PEND_W = 11;
	localparam logic [15:0] VOL_RESET = 16'h0040;
	localparam logic [15:0] VOL_MAX = 16'h00FF;
	localparam logic [7:0] SPEED_NORMAL = 8'h01;
	localparam logic [7:0] SPEED_MAX = 8'h04;
	localparam logic [7:0] CH_NL = 8'h0A;
	localparam logic [7:0] CH_F = 8'h66;
	localparam logic [7:0] CH_C = 8'h63;
	localparam logic [7:0] CH_CANCEL = 8'h43;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_PAUSE = 8'h3D;
	localparam logic [7:0] CH_RESUME = 8'h3E;
	localparam logic [7:0] CH_FAST = 8'hBB;
	localparam logic [7:0] CH_NEXT = 8'h6E;
	localparam logic [7:0] CH_PREV = 8'h70;
	localparam logic [7:0] CH_INFO = 8'h3F;
	localparam logic [7:0] CH_LIST = 8'h4C;
	localparam logic [7:0] CH_NAME = 8'h50;
	localparam logic [7:0] CH_VOL = 8'h76;
	localparam logic [7:0] CH_D0 = 8'h30;
	localparam logic [7:0] CH_D9 = 8'h39;
	localparam logic [23:0] S_OFF = "OFF";
	localparam logic [23:0] S_FAT = "fat";
	localparam logic [39:0] S_NOFAT = "nofat";
	localparam logic [39:0] S_FILES = "files";
	localparam logic [31:0] S_PLAY = "play";
	localparam logic [31:0] S_DONE = "done";
	localparam logic [15:0] S_SD = "SD";
	localparam logic [23:0] S_NOSD = "!SD";
	localparam logic [23:0] S_SPI = "SPI";
	localparam logic [87:0] S_ATT = "USB Attach ";
	localparam logic [87:0] S_DET = "USB Detach ";
	// version text is arbitrary, not a real release number
	localparam logic [71:0] S_VER = "v9.99uart";
	localparam int P_VER = 0;
	localparam int P_FLASH = 1;
	localparam int P_FAT = 2;
	localparam int P_FILES = 3;
	localparam int P_SD = 4;
	localparam int P_NOSD = 5;
	localparam int P_ATT = 6;
	localparam int P_DET = 7;
	localparam int P_PLAY = 8;
	localparam int P_DONE = 9;
	localparam int P_REPLY = 10;
	localparam logic [PEND_W-1:0] PEND_BOOT = 11'h003;

	typedef enum logic [1:0] {
		UPC_RX_IDLE = 2'b00,
		UPC_RX_START = 2'b01,
		UPC_RX_DATA = 2'b10,
		UPC_RX_STOP = 2'b11
	} upc_rx_e;

	typedef struct packed {
		logic [1:0] rx_s, card_s, usb_s, pwr_s;
		logic card_prev, usb_prev, pwr_prev;
		upc_rx_e rx_st;
		logic [8:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic tx_busy, tx_out;
		logic [8:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic [MSG_BYTES*8-1:0] msg;
		logic [4:0] msg_len, msg_idx;
		logic msg_active;
		logic [PEND_W-1:0] pend;
		logic [7:0] reply;
		logic [LINE_BYTES-1:0][7:0] line;
		logic [3:0] line_len;
		logic line_ovf;
		logic file_mode, paused, source_card, mass_storage, usb_card;
		logic power_down;
		logic [15:0] volume;
		logic [7:0] speed;
		logic next_req, prev_req, cancel_req, list_req;
		logic play_idx_req, play_name_req;
		logic [15:0] play_idx;
		logic [87:0] play_name;
	} upc_state_s;
endpackage

// ==== rtl/upc_player_cmd.sv ====
// serial command interpreter and status reporter of the audio player
// Contract
// - serial link runs at 115200 bits per second, 8N1
// - after reset the block starts in continuous mode
// - card presence selects the card as file source
// - at start-up send the version string, then flash information
// - valid filesystem: send fat, four size bytes high first, newline
// - no valid filesystem: send nofat and newline
// - valid disk: send files, two-byte file count, newline
// - playback start: send play, two-byte number, 8.3 name, newline
// - file end: send done and newline; continuous mode advances
// - f selects file mode, c continuous, C cancels and answers c
// - plus and minus step volume, answered by two-byte volume
// - = pauses, > resumes normal speed, 0xBB speeds up, answered
// - n skips forward answered n, p goes back answered p
// - ? answers four-byte seconds then one-byte remaining indicator
// - file mode plays nothing itself and parses newline-ended lines
// - OFF powers down; power button pulse wakes the block
// - file mode c returns to continuous, L lists files
// - P plus name plays by name, p by index, v sets volume
// - card insertion sends SD and newline, filesystem report follows
// - card removal sends !SD and newline, back to flash
// - USB attach and detach send matching messages naming the source
// - mode and volume survive changes of file source
`timescale 1ns/1ps
module upc_player_cmd (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic uart_rx,
	input wire logic card_present,
	input wire logic usb_attached,
	input wire logic power_button_line,
	input wire logic [23:0] flash_info,
	input wire logic fs_report,
	input wire logic fat_valid,
	input wire logic [31:0] fat_size,
	input wire logic [15:0] file_count,
	input wire logic play_started,
	input wire logic [15:0] file_num,
	input wire logic [87:0] file_name,
	input wire logic play_done,
	input wire logic [31:0] play_seconds,
	input wire logic [7:0] file_left,
	output logic uart_tx,
	output logic file_mode,
	output logic paused,
	output logic [7:0] speed,
	output logic [15:0] volume,
	output logic source_card,
	output logic mass_storage,
	output logic power_down,
	output logic next_req,
	output logic prev_req,
	output logic cancel_req,
	output logic list_req,
	output logic play_idx_req,
	output logic [15:0] play_idx,
	output logic play_name_req,
	output logic [87:0] play_name
);
	upc_pkg::upc_state_s r_reg, r_next;

	function automatic logic [159:0] left(input logic [159:0] v,
		input int nbytes);
		return v << (8 * (upc_pkg::MSG_BYTES - nbytes));
	endfunction

	function automatic logic is_digit(input logic [7:0] b);
		return b >= upc_pkg::CH_D0 && b <= upc_pkg::CH_D9;
	endfunction

	// decimal argument after the command letter; false when not numeric
	function automatic logic dec_ok(
		input logic [upc_pkg::LINE_BYTES-1:0][7:0] ln,
		input logic [3:0] len);
		logic ok;
		ok = len > 4'h1;
		for (int i = 1; i < upc_pkg::LINE_BYTES; i++) begin
			if (i < len && !is_digit(ln[i]))
				ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic [15:0] dec_val(
		input logic [upc_pkg::LINE_BYTES-1:0][7:0] ln,
		input logic [3:0] len);
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 1; i < upc_pkg::LINE_BYTES; i++) begin
			if (i < len)
				v = 16'(v * 16'h000A) + {8'h00, ln[i] - upc_pkg::CH_D0};
		end
		return v;
	endfunction

	always_comb begin
		logic rx_done;
		logic [7:0] b;
		logic [3:0] ll;
		int sel;
		logic rep_pend;
		rx_done = 1'b0;
		b = r_reg.rx_sh;
		ll = r_reg.line_len;
		sel = upc_pkg::PEND_W;
		rep_pend = 1'b0;
		r_next = r_reg;
		r_next.next_req = 1'b0;
		r_next.prev_req = 1'b0;
		r_next.cancel_req = 1'b0;
		r_next.list_req = 1'b0;
		r_next.play_idx_req = 1'b0;
		r_next.play_name_req = 1'b0;
		r_next.rx_s = {r_reg.rx_s[0], uart_rx};
		r_next.card_s = {r_reg.card_s[0], card_present};
		r_next.usb_s = {r_reg.usb_s[0], usb_attached};
		r_next.pwr_s = {r_reg.pwr_s[0], power_button_line};
		r_next.card_prev = r_reg.card_s[1];
		r_next.usb_prev = r_reg.usb_s[1];
		r_next.pwr_prev = r_reg.pwr_s[1];

		// receiver: centre of start bit, then one full bit per sample
		r_next.rx_cnt = r_reg.rx_cnt + 9'h001;
		case (r_reg.rx_st)
			upc_pkg::UPC_RX_IDLE: begin
				r_next.rx_cnt = 9'h000;
				if (!r_reg.rx_s[1])
					r_next.rx_st = upc_pkg::UPC_RX_START;
			end
			upc_pkg::UPC_RX_START: begin
				if (r_reg.rx_cnt == upc_pkg::BAUD_HALF - 9'h001) begin
					r_next.rx_cnt = 9'h000;
					r_next.rx_bit = 3'h0;
					r_next.rx_st = r_reg.rx_s[1] ? upc_pkg::UPC_RX_IDLE :
						upc_pkg::UPC_RX_DATA;
				end
			end
			upc_pkg::UPC_RX_DATA: begin
				if (r_reg.rx_cnt == upc_pkg::BAUD_DIV - 9'h001) begin
					r_next.rx_cnt = 9'h000;
					r_next.rx_sh = {r_reg.rx_s[1], r_reg.rx_sh[7:1]};
					r_next.rx_bit = r_reg.rx_bit + 3'h1;
					if (r_reg.rx_bit == 3'h7)
						r_next.rx_st = upc_pkg::UPC_RX_STOP;
				end
			end
			upc_pkg::UPC_RX_STOP: begin
				if (r_reg.rx_cnt == upc_pkg::BAUD_DIV - 9'h001) begin
					// a framing error drops the byte
					rx_done = r_reg.rx_s[1];
					r_next.rx_st = upc_pkg::UPC_RX_IDLE;
				end
			end
			default: r_next.rx_st = upc_pkg::UPC_RX_IDLE;
		endcase

		// transmitter: start, eight data bits lsb first, stop
		if (r_reg.tx_busy) begin
			r_next.tx_cnt = r_reg.tx_cnt + 9'h001;
			if (r_reg.tx_cnt == upc_pkg::BAUD_DIV - 9'h001) begin
				r_next.tx_cnt = 9'h000;
				r_next.tx_sh = {1'b1, r_reg.tx_sh[9:1]};
				r_next.tx_out = r_reg.tx_sh[1];
				r_next.tx_bit = r_reg.tx_bit - 4'h1;
				if (r_reg.tx_bit == 4'h1)
					r_next.tx_busy = 1'b0;
			end
		end else if (r_reg.msg_active) begin
			r_next.tx_sh = {1'b1, r_reg.msg[159 - 8 * r_reg.msg_idx -: 8],
				1'b0};
			r_next.tx_out = 1'b0;
			r_next.tx_busy = 1'b1;
			r_next.tx_bit = 4'hA;
			r_next.tx_cnt = 9'h000;
			r_next.msg_idx = r_reg.msg_idx + 5'h01;
			if (r_reg.msg_idx == r_reg.msg_len - 5'h01)
				r_next.msg_active = 1'b0;
		end

		// message builder; lowest pending index goes first
		for (int i = upc_pkg::PEND_W - 1; i >= 0; i--) begin
			if (r_reg.pend[i])
				sel = i;
		end
		if (!r_reg.msg_active && sel < upc_pkg::PEND_W) begin
			r_next.pend[sel] = 1'b0;
			r_next.msg_active = 1'b1;
			r_next.msg_idx = 5'h00;
			case (sel)
				upc_pkg::P_VER: begin
					r_next.msg = left(160'(upc_pkg::S_VER), 9);
					r_next.msg_len = 5'd9;
				end
				upc_pkg::P_FLASH: begin
					r_next.msg = left(160'({flash_info, upc_pkg::CH_NL}), 4);
					r_next.msg_len = 5'd4;
				end
				upc_pkg::P_FAT: begin
					if (fat_valid) begin
						r_next.msg = left(160'({upc_pkg::S_FAT, fat_size,
							upc_pkg::CH_NL}), 8);
						r_next.msg_len = 5'd8;
					end else begin
						r_next.msg = left(160'({upc_pkg::S_NOFAT,
							upc_pkg::CH_NL}), 6);
						r_next.msg_len = 5'd6;
					end
				end
				upc_pkg::P_FILES: begin
					r_next.msg = left(160'({upc_pkg::S_FILES, file_count,
						upc_pkg::CH_NL}), 8);
					r_next.msg_len = 5'd8;
				end
				upc_pkg::P_SD: begin
					r_next.msg = left(160'({upc_pkg::S_SD, upc_pkg::CH_NL}), 3);
					r_next.msg_len = 5'd3;
				end
				upc_pkg::P_NOSD: begin
					r_next.msg = left(160'({upc_pkg::S_NOSD, upc_pkg::CH_NL}), 4);
					r_next.msg_len = 5'd4;
				end
				upc_pkg::P_ATT, upc_pkg::P_DET: begin
					r_next.msg_len = r_reg.usb_card ? 5'd14 : 5'd15;
					r_next.msg = r_reg.usb_card ?
						left(160'({sel == upc_pkg::P_ATT ? upc_pkg::S_ATT :
						upc_pkg::S_DET, upc_pkg::S_SD, upc_pkg::CH_NL}), 14) :
						left(160'({sel == upc_pkg::P_ATT ? upc_pkg::S_ATT :
						upc_pkg::S_DET, upc_pkg::S_SPI, upc_pkg::CH_NL}), 15);
				end
				upc_pkg::P_PLAY: begin
					r_next.msg = left({16'h0000, upc_pkg::S_PLAY, file_num,
						file_name, upc_pkg::CH_NL}, 18);
					r_next.msg_len = 5'd18;
				end
				upc_pkg::P_DONE: begin
					r_next.msg = left(160'({upc_pkg::S_DONE, upc_pkg::CH_NL}), 5);
					r_next.msg_len = 5'd5;
				end
				default: begin
					r_next.msg = left(160'(r_reg.reply), 1);
					r_next.msg_len = 5'd1;
					case (r_reg.reply)
						upc_pkg::CH_CANCEL:
							r_next.msg = left(160'(upc_pkg::CH_C), 1);
						upc_pkg::CH_PLUS, upc_pkg::CH_MINUS: begin
							r_next.msg = left(160'(r_reg.volume), 2);
							r_next.msg_len = 5'd2;
						end
						upc_pkg::CH_FAST:
							r_next.msg = left(160'(r_reg.speed), 1);
						upc_pkg::CH_INFO: begin
							r_next.msg = left(160'({play_seconds, file_left}), 5);
							r_next.msg_len = 5'd5;
						end
						default: ; // echo of =, >, n and p
					endcase
				end
			endcase
		end

		// events from the player datapath; set after clear so it wins
		if (fs_report) begin
			r_next.pend[upc_pkg::P_FAT] = 1'b1;
			if (fat_valid)
				r_next.pend[upc_pkg::P_FILES] = 1'b1;
		end
		if (play_started)
			r_next.pend[upc_pkg::P_PLAY] = 1'b1;
		if (play_done) begin
			r_next.pend[upc_pkg::P_DONE] = 1'b1;
			if (!r_reg.file_mode)
				r_next.next_req = 1'b1;
		end
		// source changes leave mode and volume alone
		if (r_reg.card_s[1] && !r_reg.card_prev && !r_reg.source_card) begin
			r_next.source_card = 1'b1;
			r_next.pend[upc_pkg::P_SD] = 1'b1;
		end
		if (!r_reg.card_s[1] && r_reg.card_prev && r_reg.source_card) begin
			r_next.source_card = 1'b0;
			r_next.pend[upc_pkg::P_NOSD] = 1'b1;
			if (r_reg.usb_card)
				r_next.mass_storage = 1'b0;
		end
		if (r_reg.usb_s[1] && !r_reg.usb_prev && !r_reg.mass_storage) begin
			r_next.mass_storage = 1'b1;
			r_next.usb_card = r_reg.source_card;
			r_next.pend[upc_pkg::P_ATT] = 1'b1;
		end
		if (!r_reg.usb_s[1] && r_reg.usb_prev && r_reg.mass_storage) begin
			r_next.mass_storage = 1'b0;
			r_next.pend[upc_pkg::P_DET] = 1'b1;
		end
		// wake only on a rising edge so a held button does not bounce us
		if (r_reg.pwr_s[1] && !r_reg.pwr_prev)
			r_next.power_down = 1'b0;
		// a byte without reply must not revive a reply built this cycle
		rep_pend = r_next.pend[upc_pkg::P_REPLY];

		if (rx_done && !r_reg.power_down && !r_reg.file_mode) begin
			r_next.reply = b;
			r_next.pend[upc_pkg::P_REPLY] = 1'b1;
			case (b)
				upc_pkg::CH_F: begin
					r_next.file_mode = 1'b1;
					r_next.pend[upc_pkg::P_REPLY] = rep_pend;
				end
				upc_pkg::CH_C: r_next.pend[upc_pkg::P_REPLY] = rep_pend;
				upc_pkg::CH_CANCEL: r_next.cancel_req = 1'b1;
				upc_pkg::CH_PLUS: begin
					if (r_reg.volume != upc_pkg::VOL_MAX)
						r_next.volume = r_reg.volume + 16'h0001;
				end
				upc_pkg::CH_MINUS: begin
					if (r_reg.volume != 16'h0000)
						r_next.volume = r_reg.volume - 16'h0001;
				end
				upc_pkg::CH_PAUSE: r_next.paused = 1'b1;
				upc_pkg::CH_RESUME: begin
					r_next.paused = 1'b0;
					r_next.speed = upc_pkg::SPEED_NORMAL;
				end
				upc_pkg::CH_FAST: begin
					if (r_reg.speed != upc_pkg::SPEED_MAX)
						r_next.speed = r_reg.speed + 8'h01;
				end
				upc_pkg::CH_NEXT: r_next.next_req = 1'b1;
				upc_pkg::CH_PREV: r_next.prev_req = 1'b1;
				upc_pkg::CH_INFO: ;
				default: r_next.pend[upc_pkg::P_REPLY] = rep_pend;
			endcase
			if (b != upc_pkg::CH_INFO &&
				b != upc_pkg::CH_PLUS &&
				b != upc_pkg::CH_MINUS && b != upc_pkg::CH_PAUSE &&
				b != upc_pkg::CH_RESUME && b != upc_pkg::CH_FAST &&
				b != upc_pkg::CH_NEXT && b != upc_pkg::CH_PREV &&
				b != upc_pkg::CH_CANCEL)
				r_next.reply = r_reg.reply;
		end else if (rx_done && !r_reg.power_down) begin
			// line assembly; an overlong line is dropped whole
			if (b == upc_pkg::CH_NL) begin
				r_next.line_len = 4'h0;
				r_next.line_ovf = 1'b0;
				if (!r_reg.line_ovf) begin
					if (ll == 4'h3 && {r_reg.line[0], r_reg.line[1],
						r_reg.line[2]} == upc_pkg::S_OFF)
						r_next.power_down = 1'b1;
					else if (ll == 4'h1 && r_reg.line[0] == upc_pkg::CH_C)
						r_next.file_mode = 1'b0;
					else if (ll == 4'h1 && r_reg.line[0] == upc_pkg::CH_LIST)
						r_next.list_req = 1'b1;
					else if (ll == 4'hC && r_reg.line[0] == upc_pkg::CH_NAME) begin
						r_next.play_name_req = 1'b1;
						for (int i = 1; i < 12; i++)
							r_next.play_name[8 * (11 - i) +: 8] = r_reg.line[i];
					end else if (r_reg.line[0] == upc_pkg::CH_PREV &&
						dec_ok(r_reg.line, ll)) begin
						r_next.play_idx_req = 1'b1;
						r_next.play_idx = dec_val(r_reg.line, ll);
					end else if (r_reg.line[0] == upc_pkg::CH_VOL &&
						dec_ok(r_reg.line, ll))
						r_next.volume = dec_val(r_reg.line, ll);
				end
			end else if (ll < 4'(upc_pkg::LINE_BYTES)) begin
				r_next.line[ll] = b;
				r_next.line_len = ll + 4'h1;
			end else
				r_next.line_ovf = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r_reg <= '0;
			r_reg.rx_s <= 2'b11;
			r_reg.tx_out <= 1'b1;
			r_reg.file_mode <= 1'b0;
			r_reg.volume <= upc_pkg::VOL_RESET;
			r_reg.speed <= upc_pkg::SPEED_NORMAL;
			r_reg.pend <= upc_pkg::PEND_BOOT;
		end else begin
			r_reg <= r_next;
		end
	end

	assign uart_tx = r_reg.tx_out;
	assign file_mode = r_reg.file_mode;
	assign paused = r_reg.paused;
	assign speed = r_reg.speed;
	assign volume = r_reg.volume;
	assign source_card = r_reg.source_card;
	assign mass_storage = r_reg.mass_storage;
	assign power_down = r_reg.power_down;
	assign next_req = r_reg.next_req;
	assign prev_req = r_reg.prev_req;
	assign cancel_req = r_reg.cancel_req;
	assign list_req = r_reg.list_req;
	assign play_idx_req = r_reg.play_idx_req;
	assign play_idx = r_reg.play_idx;
	assign play_name_req = r_reg.play_name_req;
	assign play_name = r_reg.play_name;
endmodule

// ==== sim/upc_host.sv ====
// serial host model: sends command bytes and collects status bytes
`timescale 1ns/1ps
module upc_host (
	input wire logic ref_clk,
	input wire logic tx_line,
	output logic rx_line
);
	logic [7:0] rxq[$];
	logic [7:0] b;
	initial rx_line = 1'b1;
	// 8N1, lsb first, idle high between frames
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			rx_line <= f[i];
			repeat (upc_pkg::BAUD_DIV - 1) @(posedge ref_clk);
		end
	endtask
	// samples mid bit; a low stop bit is stored as unknown to force a mismatch
	initial begin
		forever begin
			@(negedge tx_line);
			repeat (upc_pkg::BAUD_HALF) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (upc_pkg::BAUD_DIV) @(posedge ref_clk);
				b[i] = tx_line;
			end
			repeat (upc_pkg::BAUD_DIV) @(posedge ref_clk);
			rxq.push_back(tx_line === 1'b1 ? b : {8{1'bx}});
		end
	end
endmodule

// ==== sim/upc_player_cmd_chk.sv ====
// assertions on the ports of the serial player command block
`timescale 1ns/1ps
module upc_player_cmd_chk (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic uart_tx,
	input wire logic card_present,
	input wire logic usb_attached,
	input wire logic file_mode,
	input wire logic [7:0] speed,
	input wire logic [15:0] volume,
	input wire logic source_card,
	input wire logic mass_storage,
	input wire logic power_down,
	input wire logic next_req,
	input wire logic cancel_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// inputs pass a two-stage synchroniser, hence the slack of 8
	sequence card_in;
		$rose(card_present) && !source_card && !mass_storage && !power_down;
	endsequence
	sequence usb_in;
		$rose(usb_attached) && !mass_storage && !power_down;
	endsequence
	chk_tx_reset_idle: assert property (disable iff (1'b0) srst |=> uart_tx)
		else $error("tx not idle in reset");
	chk_speed_in_range: assert property (speed >= upc_pkg::SPEED_NORMAL
		&& speed <= upc_pkg::SPEED_MAX)
		else $error("speed out of range");
	chk_volume_step_one: assert property ($changed(volume) && !$past(file_mode)
		|-> volume == $past(volume) + 16'h0001
		|| volume == $past(volume) - 16'h0001)
		else $error("volume step not one");
	chk_file_no_advance: assert property (file_mode |-> !next_req)
		else $error("advance in file mode");
	chk_next_one_cycle: assert property (next_req |=> !next_req)
		else $error("next pulse too long");
	chk_cancel_one_cycle: assert property ($rose(cancel_req)
		|=> $fell(cancel_req))
		else $error("cancel pulse too long");
	chk_card_selects: assert property (card_in |-> ##[1:8] source_card)
		else $error("card not selected");
	chk_card_removal: assert property ($fell(card_present) && source_card
		|-> ##[1:8] !source_card)
		else $error("card source kept");
	chk_usb_enters: assert property (usb_in |-> ##[1:8] mass_storage)
		else $error("no mass storage");
	chk_source_keeps: assert property ($changed(source_card)
		|-> $stable(volume) && $stable(file_mode))
		else $error("settings lost on source change");
	chk_off_frozen: assert property (power_down && $past(power_down)
		|-> $stable(volume) && $stable(file_mode))
		else $error("state moved while off");
endmodule

bind upc_player_cmd upc_player_cmd_chk u_chk (.ref_clk, .srst, .uart_tx,
	.card_present, .usb_attached, .file_mode, .speed, .volume, .source_card,
	.mass_storage, .power_down, .next_req, .cancel_req);

// ==== sim/upc_player_cmd_test.sv ====
// self-checking bench of the serial player command block
`timescale 1ns/1ps
module upc_player_cmd_test;
	logic ref_clk, srst, uart_rx, card_present, usb_attached;
	logic power_button_line, fs_report, fat_valid, play_started, play_done;
	logic uart_tx, file_mode, paused, source_card, mass_storage, power_down;
	logic next_req, prev_req, cancel_req, list_req, play_idx_req;
	logic play_name_req;
	logic [23:0] flash_info;
	logic [31:0] fat_size, play_seconds;
	logic [15:0] file_count, file_num, volume, play_idx;
	logic [87:0] file_name, play_name;
	logic [7:0] file_left, speed;
	int bad_count, num_checks, n_next, n_prev, n_cancel, n_list, n_pick;
	upc_player_cmd u_dut (.ref_clk, .srst, .uart_rx, .card_present,
		.usb_attached, .power_button_line, .flash_info, .fs_report, .fat_valid,
		.fat_size, .file_count, .play_started, .file_num, .file_name,
		.play_done, .play_seconds, .file_left, .uart_tx, .file_mode, .paused,
		.speed, .volume, .source_card, .mass_storage, .power_down, .next_req,
		.prev_req, .cancel_req, .list_req, .play_idx_req, .play_idx,
		.play_name_req, .play_name);
	upc_host u_host (.ref_clk, .tx_line(uart_tx), .rx_line(uart_rx));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		n_next += int'(next_req === 1'b1);
		n_prev += int'(prev_req === 1'b1);
		n_cancel += int'(cancel_req === 1'b1);
		n_list += int'(list_req === 1'b1);
		n_pick += int'(play_idx_req === 1'b1 || play_name_req === 1'b1);
	end
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic exp_b(input logic [7:0] e);
		int n;
		n = 0;
		while (u_host.rxq.size() == 0 && n < 9000) begin
			@(posedge ref_clk);
			n++;
		end
		if (u_host.rxq.size() == 0)
			chk(1'b0, "missing byte");
		else
			chk(u_host.rxq.pop_front() === e, "wrong byte");
	endtask
	task automatic exp_s(input logic [159:0] s, input int n);
		for (int i = n - 1; i >= 0; i--)
			exp_b(s[8*i+:8]);
	endtask
	task automatic rt(input logic [7:0] c, input logic [39:0] e, input int n);
		u_host.send(c);
		exp_s(e, n);
	endtask
	// whole line, then the terminating newline
	task automatic line(input logic [95:0] s, input int n);
		for (int i = n - 1; i >= 0; i--)
			u_host.send(s[8*i+:8]);
		u_host.send(upc_pkg::CH_NL);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic t_boot();
		exp_s(upc_pkg::S_VER, 9);
		exp_s({flash_info, upc_pkg::CH_NL}, 4);
		chk(file_mode === 1'b0, "not continuous");
	endtask
	task automatic t_fs();
		@(posedge ref_clk) fs_report <= 1'b1;
		@(posedge ref_clk) fs_report <= 1'b0;
		exp_s({upc_pkg::S_FAT, fat_size, upc_pkg::CH_NL}, 8);
		exp_s({upc_pkg::S_FILES, file_count, upc_pkg::CH_NL}, 8);
		@(posedge ref_clk) fat_valid <= 1'b0;
		fs_report <= 1'b1;
		@(posedge ref_clk) fs_report <= 1'b0;
		exp_s({upc_pkg::S_NOFAT, upc_pkg::CH_NL}, 6);
	endtask
	task automatic t_play();
		@(posedge ref_clk) play_started <= 1'b1;
		@(posedge ref_clk) play_started <= 1'b0;
		exp_s({upc_pkg::S_PLAY, file_num, file_name, upc_pkg::CH_NL}, 18);
		@(posedge ref_clk) play_done <= 1'b1;
		@(posedge ref_clk) play_done <= 1'b0;
		exp_s({upc_pkg::S_DONE, upc_pkg::CH_NL}, 5);
		chk(n_next == 1, "no auto advance");
	endtask
	task automatic t_cont();
		rt(upc_pkg::CH_PLUS, upc_pkg::VOL_RESET + 16'h0001, 2);
		rt(upc_pkg::CH_MINUS, upc_pkg::VOL_RESET, 2);
		rt(upc_pkg::CH_PAUSE, upc_pkg::CH_PAUSE, 1);
		chk(paused === 1'b1, "not paused");
		rt(upc_pkg::CH_FAST, upc_pkg::SPEED_NORMAL + 8'h01, 1);
		rt(upc_pkg::CH_RESUME, upc_pkg::CH_RESUME, 1);
		chk(paused === 1'b0 && speed === upc_pkg::SPEED_NORMAL, "resume");
		rt(upc_pkg::CH_NEXT, upc_pkg::CH_NEXT, 1);
		rt(upc_pkg::CH_PREV, upc_pkg::CH_PREV, 1);
		chk(n_next == 2 && n_prev == 1, "skip");
		rt(upc_pkg::CH_INFO, {play_seconds, file_left}, 5);
		rt(upc_pkg::CH_CANCEL, upc_pkg::CH_C, 1);
		chk(n_cancel == 1, "no cancel");
		u_host.send(upc_pkg::CH_C);
		u_host.send(8'h78);
		repeat (4000) @(posedge ref_clk);
		chk(u_host.rxq.size() == 0 && volume === 16'h0040 &&
			file_mode === 1'b0, "junk");
	endtask
	task automatic t_file();
		u_host.send(upc_pkg::CH_F);
		repeat (4) @(posedge ref_clk);
		chk(file_mode === 1'b1, "no file mode");
		line("L", 1);
		chk(n_list == 1, "no list");
		line("p12", 3);
		chk(play_idx === 16'h000C, "index");
		line("v5", 2);
		chk(volume === 16'h0005, "set volume");
		line("PAUDIO01 OGG", 12);
		chk(play_name === 88'("AUDIO01 OGG") && n_pick == 2, "by name");
		line("zz", 2);
		@(posedge ref_clk) play_done <= 1'b1;
		@(posedge ref_clk) play_done <= 1'b0;
		exp_s({upc_pkg::S_DONE, upc_pkg::CH_NL}, 5);
		chk(n_next == 2 && volume === 16'h0005, "file idle");
		line("c", 1);
		chk(file_mode === 1'b0, "not back");
	endtask
	task automatic t_card();
		@(posedge ref_clk) card_present <= 1'b1;
		exp_s({upc_pkg::S_SD, upc_pkg::CH_NL}, 3);
		chk(source_card === 1'b1 && volume === 16'h0005, "card");
		@(posedge ref_clk) usb_attached <= 1'b1;
		exp_s({upc_pkg::S_ATT, upc_pkg::S_SD, upc_pkg::CH_NL}, 14);
		chk(mass_storage === 1'b1, "no storage");
		@(posedge ref_clk) usb_attached <= 1'b0;
		exp_s({upc_pkg::S_DET, upc_pkg::S_SD, upc_pkg::CH_NL}, 14);
		@(posedge ref_clk) card_present <= 1'b0;
		exp_s({upc_pkg::S_NOSD, upc_pkg::CH_NL}, 4);
		chk(source_card === 1'b0 && file_mode === 1'b0, "flash");
	endtask
	task automatic t_off();
		u_host.send(upc_pkg::CH_F);
		line("OFF", 3);
		chk(power_down === 1'b1, "not off");
		@(posedge ref_clk) power_button_line <= 1'b1;
		repeat (20) @(posedge ref_clk);
		power_button_line <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk(power_down === 1'b0, "no wake");
	endtask
	// run length is set by the fixed line rate, not by the block
	initial begin
		repeat (700000) @(posedge ref_clk);
		bad_count++;
		test_done();
	end
	initial begin
		srst = 1'b1;
		card_present = 1'b0;
		usb_attached = 1'b0;
		power_button_line = 1'b0;
		fs_report = 1'b0;
		fat_valid = 1'b1;
		play_started = 1'b0;
		play_done = 1'b0;
		flash_info = 24'h1A2B3C;
		fat_size = 32'h00000FC0;
		file_count = 16'h0004;
		file_num = 16'h0002;
		file_name = "AUDIO01 OGG";
		play_seconds = 32'h0001E240;
		file_left = 8'h80;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		t_boot();
		t_fs();
		t_play();
		t_cont();
		t_file();
		t_card();
		t_off();
		test_done();
	end
endmodule
